/* core/dtcs_sequencer.v */
// dma transfer cycle sequencer with ahb-lite register slave
// Operation
// - each unit: source read then destination write
// - 16-bit unit, 16-bit bus, odd source: extra read
// - 16-bit unit, 16-bit bus, odd destination: extra write
// - 16-bit unit, 8-bit bus expansion mode: two byte cycles each
// - dma_unit uses width pin for internal areas
// - software waits lengthen access by their count
// - external accesses stretched while ready_n low
// - write phase follows read phase rules separately
// - unit_size_select clear 16-bit, set 8-bit
// - total cycles sum read and write lengths
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`include "dtcs_map.vh"
`default_nettype none
module dtcs_sequencer #(
   parameter AW = 20 // bus address width
) (
   input wire clk,
   input wire rstn,
   input wire ce,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // pins
   input wire width_sel,
   input wire ready_n,
   // system bus side
   input wire [15:0] rd_data,
   output reg [AW-1:0] bus_addr,
   output reg bus_rd,
   output reg bus_wr,
   output reg bus_dummy,
   output reg dma_owns_bus,
   output reg [15:0] wr_data
);
   // pin synchronisers
   reg width_s1; // first stage, read only by second
   reg width_s2; // synchronised width select
   reg ready_s1; // first stage, read only by second
   reg ready_s2; // synchronised ready, active low

   // software visible state and the read capture marks
   reg unit_size_select; // 0 16-bit units, 1 8-bit units
   reg exp_mode; // memory expansion or microprocessor mode
   reg [AW-1:0] src_addr; // source address
   reg [AW-1:0] dst_addr; // destination address
   reg [5:0] wait_cfg; // software waits and external flags
   reg done_flag; // sticky unit complete flag
   reg [7:0] last_total; // cycles of the last unit
   reg [15:0] data_word; // assembled unit data
   reg rd_cend_q; // a read bus cycle ended one clock ago
   reg rd_idx_q; // index of that read bus cycle

   // bus slave state
   reg dp_wr; // data phase of a write pending
   reg [7:0] dp_addr; // latched write offset

   // sequencer state
   reg [1:0] state; // current sequencer state
   reg [1:0] next_state; // next sequencer state
   reg [7:0] total_cnt; // running cycle count of the unit

   // derived controls
   wire width8; // data bus is 8 bits
   wire size16; // transfer unit is 16 bits
   wire [1:0] rd_cycles; // bus cycles of read phase
   wire [1:0] wr_cycles; // bus cycles of write phase
   wire start_req; // software start
   wire addr_ph; // valid address phase
   wire wr_hit; // write data phase this cycle
   wire done_clr; // software clears done flag
   wire rd_start; // launch read phase
   wire rd_busy; // read phase running
   wire rd_idx; // read bus cycle index
   wire rd_cend; // read bus cycle ends
   wire rd_done; // read phase finished
   wire wr_busy; // write phase running
   wire wr_idx; // write bus cycle index
   wire wr_done; // write phase finished
   wire unit_end; // dummy cycle ends the unit
   wire [15:0] next_data_word; // word with the byte now on the bus

   // width pin only counts in expansion modes, for any area
   assign width8 = exp_mode & width_s2;
   assign size16 = ~unit_size_select;

   // per-phase bus cycle counts, each judged on its own address
   assign rd_cycles = (size16 & (width8 | src_addr[0])) ?
                      `DTCS_CYC_TWO : `DTCS_CYC_ONE;
   assign wr_cycles = (size16 & (width8 | dst_addr[0])) ?
                      `DTCS_CYC_TWO : `DTCS_CYC_ONE;

   // ahb decode
   assign addr_ph = hsel & hready & htrans[`DTCS_HTRANS_ACT];
   assign wr_hit = dp_wr;
   assign start_req = wr_hit && (dp_addr == `DTCS_OFS_CTRL) &&
                      hwdata[`DTCS_CTRL_START];
   assign done_clr = wr_hit && (dp_addr == `DTCS_OFS_STAT) &&
                     hwdata[`DTCS_STAT_DONE];
   assign rd_start = (state == `DTCS_ST_IDLE) && start_req;
   assign unit_end = (state == `DTCS_ST_DUMMY);

   // read phase
   dtcs_phase u_rd (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .start(rd_start),
      .num_cycles(rd_cycles),
      .waits(wait_cfg[`DTCS_WAIT_SRC_HI:`DTCS_WAIT_SRC_LO]),
      .stretch_en(exp_mode & wait_cfg[`DTCS_WAIT_SRC_EXT]),
      .ready_low(~ready_s2),
      .busy(rd_busy),
      .cyc_idx(rd_idx),
      .cyc_end(rd_cend),
      .done(rd_done)
   );

   // write phase, launched straight from the end of the read
   dtcs_phase u_wr (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .start(rd_done),
      .num_cycles(wr_cycles),
      .waits(wait_cfg[`DTCS_WAIT_DST_HI:`DTCS_WAIT_DST_LO]),
      .stretch_en(exp_mode & wait_cfg[`DTCS_WAIT_DST_EXT]),
      .ready_low(~ready_s2),
      .busy(wr_busy),
      .cyc_idx(wr_idx),
      .cyc_end(),
      .done(wr_done)
   );

   // two-stage synchronisers for the pins
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         width_s1 <= 1'b0;
         width_s2 <= 1'b0;
         ready_s1 <= 1'b1;
         ready_s2 <= 1'b1;
      end else if (ce) begin
         width_s1 <= width_sel;
         width_s2 <= width_s1;
         ready_s1 <= ready_n;
         ready_s2 <= ready_s1;
      end
   end

   // sequencer next state
   always @* begin
      next_state = state;
      case (state)
         `DTCS_ST_IDLE: begin
            if (rd_start) begin
               next_state = `DTCS_ST_RD;
            end
         end
         `DTCS_ST_RD: begin
            if (rd_done) begin
               next_state = `DTCS_ST_WR;
            end
         end
         `DTCS_ST_WR: begin
            if (wr_done) begin
               next_state = `DTCS_ST_DUMMY;
            end
         end
         `DTCS_ST_DUMMY: begin
            next_state = `DTCS_ST_IDLE;
         end
         default: begin
            next_state = `DTCS_ST_IDLE;
         end
      endcase
   end

   // sequencer state and cycle total
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= `DTCS_ST_IDLE;
         total_cnt <= `DTCS_RST_CNT;
         last_total <= `DTCS_RST_CNT;
      end else if (ce) begin
         state <= next_state;
         if (rd_start) begin
            total_cnt <= `DTCS_RST_CNT;
         end else if (state == `DTCS_ST_RD || state == `DTCS_ST_WR) begin
            total_cnt <= total_cnt + 8'h01;
         end
         if (unit_end) begin
            last_total <= total_cnt;
         end
      end
   end

   // bus outputs lag the phase by a clock, so the byte of a read bus cycle
   // stands one clock after the phase ends it: low byte first, then high
   assign next_data_word = !rd_cend_q ? data_word :
      (rd_cycles == `DTCS_CYC_ONE) ? rd_data :
      rd_idx_q ? {rd_data[7:0], data_word[7:0]} :
      {data_word[15:8], rd_data[7:0]};
   // read data capture and the delayed end-of-cycle marks
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_word <= `DTCS_RST_DATA;
         rd_cend_q <= 1'b0;
         rd_idx_q <= 1'b0;
      end else if (ce) begin
         data_word <= next_data_word;
         rd_cend_q <= rd_cend;
         rd_idx_q <= rd_idx;
      end
   end

   // system bus outputs, one clock behind phase state
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_addr <= `DTCS_RST_ADDR;
         bus_rd <= 1'b0;
         bus_wr <= 1'b0;
         bus_dummy <= 1'b0;
         dma_owns_bus <= 1'b0;
         wr_data <= `DTCS_RST_DATA;
      end else if (ce) begin
         bus_rd <= rd_busy;
         bus_wr <= wr_busy;
         bus_dummy <= unit_end;
         dma_owns_bus <= (state != `DTCS_ST_IDLE) || rd_start;
         if (rd_busy) begin
            bus_addr <= src_addr + {{(AW-1){1'b0}}, rd_idx};
         end else if (wr_busy) begin
            bus_addr <= dst_addr + {{(AW-1){1'b0}}, wr_idx};
         end
         if (wr_busy) begin
            // the last read byte may arrive at this very edge
            if (wr_cycles == `DTCS_CYC_ONE) begin
               wr_data <= next_data_word;
            end else if (!wr_idx) begin
               wr_data <= {8'h00, next_data_word[7:0]};
            end else begin
               wr_data <= {8'h00, next_data_word[15:8]};
            end
         end
      end
   end

   // ahb data phase tracking, zero wait slave
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dp_wr <= 1'b0;
         dp_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dp_wr <= addr_ph & hwrite;
         if (addr_ph) begin
            dp_addr <= haddr[7:0];
         end
      end
   end

   // register writes
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         unit_size_select <= 1'b0;
         exp_mode <= 1'b0;
         src_addr <= `DTCS_RST_ADDR;
         dst_addr <= `DTCS_RST_ADDR;
         wait_cfg <= `DTCS_RST_WAIT;
         done_flag <= 1'b0;
      end else if (ce) begin
         // settings locked while a unit is in flight
         if (wr_hit && state == `DTCS_ST_IDLE) begin
            case (dp_addr)
               `DTCS_OFS_CTRL: begin
                  unit_size_select <= hwdata[`DTCS_CTRL_SIZE];
                  exp_mode <= hwdata[`DTCS_CTRL_EXP];
               end
               `DTCS_OFS_SRC: begin
                  src_addr <= hwdata[AW-1:0];
               end
               `DTCS_OFS_DST: begin
                  dst_addr <= hwdata[AW-1:0];
               end
               `DTCS_OFS_WAIT: begin
                  wait_cfg <= hwdata[5:0];
               end
               default: begin
                  src_addr <= src_addr; // unmapped: ignored
               end
            endcase
         end
         // set wins over a clear in the same cycle
         if (unit_end) begin
            done_flag <= 1'b1;
         end else if (done_clr) begin
            done_flag <= 1'b0;
         end
      end
   end

   // register read data, loaded at the address phase
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hrdata <= `DTCS_RST_WORD;
      end else if (ce) begin
         if (addr_ph && !hwrite) begin
            case (haddr[7:0])
               `DTCS_OFS_CTRL: begin
                  hrdata <= {29'h0, exp_mode, unit_size_select, 1'b0};
               end
               `DTCS_OFS_SRC: begin
                  hrdata <= {{(32-AW){1'b0}}, src_addr};
               end
               `DTCS_OFS_DST: begin
                  hrdata <= {{(32-AW){1'b0}}, dst_addr};
               end
               `DTCS_OFS_WAIT: begin
                  hrdata <= {26'h0, wait_cfg};
               end
               `DTCS_OFS_STAT: begin
                  hrdata <= {16'h0, last_total, 6'h0, done_flag,
                             (state != `DTCS_ST_IDLE)};
               end
               `DTCS_OFS_DATA: begin
                  hrdata <= {16'h0, data_word};
               end
               default: begin
                  hrdata <= `DTCS_RST_WORD; // unmapped reads zero
               end
            endcase
         end
      end
   end
endmodule // dtcs_sequencer
`default_nettype wire

/* core/dtcs_map.vh */
// constants for the dma transfer cycle sequencer: offsets, fields, states
`ifndef DTCS_MAP_VH
`define DTCS_MAP_VH
// register word offsets (byte addresses)
`define DTCS_OFS_CTRL 8'h00
`define DTCS_OFS_SRC 8'h04
`define DTCS_OFS_DST 8'h08
`define DTCS_OFS_WAIT 8'h0c
`define DTCS_OFS_STAT 8'h10
`define DTCS_OFS_DATA 8'h14
// control register fields
`define DTCS_CTRL_START 0
`define DTCS_CTRL_SIZE 1
`define DTCS_CTRL_EXP 2
// wait register fields
`define DTCS_WAIT_SRC_LO 0
`define DTCS_WAIT_SRC_HI 1
`define DTCS_WAIT_DST_LO 2
`define DTCS_WAIT_DST_HI 3
`define DTCS_WAIT_SRC_EXT 4
`define DTCS_WAIT_DST_EXT 5
// status register fields
`define DTCS_STAT_BUSY 0
`define DTCS_STAT_DONE 1
`define DTCS_STAT_CNT_LO 8
`define DTCS_STAT_CNT_HI 15
// reset values
`define DTCS_RST_WORD 32'h0000_0000
`define DTCS_RST_ADDR 20'h00000
`define DTCS_RST_WAIT 6'h00
`define DTCS_RST_CNT 8'h00
`define DTCS_RST_DATA 16'h0000
// bus cycle counts per phase
`define DTCS_CYC_ONE 2'h1
`define DTCS_CYC_TWO 2'h2
// sequencer states
`define DTCS_ST_IDLE 2'h0
`define DTCS_ST_RD 2'h1
`define DTCS_ST_WR 2'h2
`define DTCS_ST_DUMMY 2'h3
// ahb transfer type bit meaning nonseq or seq
`define DTCS_HTRANS_ACT 1
`endif

/* core/dtcs_phase.v */
// one bus phase (read or write): counts bus cycles, waits and ready stretch
`include "dtcs_map.vh"
`default_nettype none
module dtcs_phase (
   input wire clk,
   input wire rstn,
   input wire ce,
   input wire start,
   input wire [1:0] num_cycles,
   input wire [1:0] waits,
   input wire stretch_en,
   input wire ready_low,
   output reg busy,
   output reg cyc_idx,
   output wire cyc_end,
   output wire done
);
   reg [1:0] wcnt; // wait states spent in current bus cycle
   wire wait_over; // software waits used up
   wire stretch; // external party asks to wait
   wire last_cyc; // current bus cycle is the final one

   assign wait_over = (wcnt == waits);
   assign stretch = stretch_en & ready_low;
   assign last_cyc = ({1'b0, cyc_idx} == (num_cycles - `DTCS_CYC_ONE));
   // bus cycle ends once waits are spent and ready is released
   assign cyc_end = busy & wait_over & ~stretch;
   assign done = cyc_end & last_cyc;

   // phase counters
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
         cyc_idx <= 1'b0;
         wcnt <= 2'h0;
      end else if (ce) begin
         if (start && !busy) begin
            busy <= 1'b1;
            cyc_idx <= 1'b0;
            wcnt <= 2'h0;
         end else if (busy) begin
            if (!wait_over) begin
               wcnt <= wcnt + 2'h1;
            end else if (stretch) begin
               wcnt <= wcnt;
            end else if (last_cyc) begin
               busy <= 1'b0;
            end else begin
               cyc_idx <= 1'b1;
               wcnt <= 2'h0;
            end
         end
      end
   end
endmodule // dtcs_phase
`default_nettype wire

/* sim/dtcs_sva.sv */
// port checker for the transfer cycle sequencer
`default_nettype none
module dtcs_sva (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic bus_rd,
   input wire logic bus_wr,
   input wire logic bus_dummy,
   input wire logic dma_owns_bus
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // a read address phase is taken at this edge
   wire rd_taken = hsel & hready & htrans[1] & ~hwrite & ce;
   a_zero_wait: assert property (hreadyout)
      else $error("slave inserted a wait");
   a_resp_okay: assert property (!hresp)
      else $error("slave gave an error response");
   a_rdata_hold: assert property (!rd_taken |=> $stable(hrdata))
      else $error("read data moved without a read");
   a_phase_excl: assert property (!(bus_rd && bus_wr))
      else $error("read and write overlap");
   a_write_follows: assert property ($fell(bus_rd) |-> bus_wr)
      else $error("gap between read and write");
   a_dummy_after: assert property ($fell(bus_wr) |-> bus_dummy)
      else $error("no dummy cycle after write");
   a_dummy_pulse: assert property (
      bus_dummy |=> !bus_dummy && !bus_rd)
      else $error("dummy cycle longer than one clock");
   a_read_first: assert property (bus_wr |=> !bus_rd)
      else $error("read follows write in one unit");
   a_bus_owned: assert property (
      bus_rd || bus_wr || bus_dummy |-> dma_owns_bus)
      else $error("bus cycle without ownership");
   // main scenarios
   c_read: cover property ($rose(bus_rd));
   c_two_reads: cover property (bus_rd [*2]);
   c_two_writes: cover property (bus_wr [*2]);
   c_dummy: cover property (bus_dummy);
endmodule // dtcs_sva
bind dtcs_sequencer dtcs_sva dtcs_sva_i (.clk(clk), .rstn(rstn), .ce(ce),
   .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus_rd(bus_rd),
   .bus_wr(bus_wr), .bus_dummy(bus_dummy), .dma_owns_bus(dma_owns_bus));
`default_nettype wire

/* sim/dtcs_mem_model.sv */
// system bus memory model: read data and ready stretch
`default_nettype none
module dtcs_mem_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic bus_rd,
   input wire logic [19:0] bus_addr,
   input wire logic dma_owns_bus,
   input wire logic [3:0] stall_len,
   output wire logic [15:0] rd_data,
   output wire logic ready_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] idle_pat; // changes every clock while released
   logic [3:0] stall_left; // clocks of wait request left
   logic own_q; // ownership one clock ago
   // wait request starts when the dma unit takes the bus
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idle_pat <= 16'h0f0f;
         stall_left <= 4'h0;
         own_q <= 1'b0;
      end else begin
         idle_pat <= ~idle_pat;
         own_q <= dma_owns_bus;
         if (dma_owns_bus && !own_q) begin
            stall_left <= stall_len;
         end else if (stall_left != 4'h0) begin
            stall_left <= stall_left - 4'h1;
         end
      end
   end
   // low asks the device to wait
   assign ready_n = (stall_left == 4'h0);
   // data is a function of address, noise when not read
   assign rd_data = bus_rd ? {bus_addr[7:0] ^ 8'h5a, bus_addr[7:0]} : idle_pat;
endmodule // dtcs_mem_model
`default_nettype wire

/* sim/tb_dtcs_sequencer.sv */
// testbench for the transfer cycle sequencer
`include "dtcs_map.vh"
`default_nettype none
module tb_dtcs_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, hsel, hwrite, width_sel;
   logic [31:0] haddr, hwdata, rv;
   logic [1:0] htrans;
   logic [3:0] stall_len;
   wire [31:0] hrdata;
   wire hreadyout, hresp, ready_n, bus_rd, bus_wr, bus_dummy, own;
   wire [15:0] rd_data, wr_data;
   wire [19:0] bus_addr;
   logic [15:0] wd_last; // data of the last write bus clock
   logic [19:0] wa_last; // address of the last write bus clock
   int fail_count, check_count, cyc, rd_cnt, wr_cnt, dm_cnt;
   dtcs_sequencer dtcs_sequencer_i (.clk(clk), .rstn(rstn), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .width_sel(width_sel),
      .ready_n(ready_n), .rd_data(rd_data), .bus_addr(bus_addr),
      .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_dummy(bus_dummy),
      .dma_owns_bus(own), .wr_data(wr_data));
   dtcs_mem_model dtcs_mem_model_i (.clk(clk), .rstn(rstn), .bus_rd(bus_rd),
      .bus_addr(bus_addr), .dma_owns_bus(own), .stall_len(stall_len),
      .rd_data(rd_data), .ready_n(ready_n));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // cycle counts of each bus phase, and the timeout
   always @(posedge clk) begin
      cyc++;
      if (bus_rd) rd_cnt++;
      if (bus_wr) wr_cnt++;
      if (bus_dummy) dm_cnt++;
      if (bus_wr) wd_last = wr_data;
      if (bus_wr) wa_last = bus_addr;
      if (cyc == 20000) begin
         fail_count++;
         end_of_test;
      end
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task check_range(input logic [31:0] got, lo, hi, input string what);
      check_count++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fail_count++;
         $display("mismatch at %0t: %s got %0d", $time, what, got);
      end
   endtask
   // one ahb-lite single word transfer
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask
   // one transfer unit with expected bus cycle counts per phase
   task run_case(input logic [2:0] ctl, input logic ws,
      input logic [7:0] src, dst, input logic [5:0] w,
      input logic [3:0] st, input int nrd, nwr);
      int erd, ewr, lx, hx;
      logic [31:0] ed, m, ew;
      erd = nrd * (1 + w[1:0]);
      ewr = nwr * (1 + w[3:2]);
      lx = (st != 0) ? 1 : 0;
      hx = (st != 0) ? st + 3 : 0;
      ed = (nrd == 2) ? {src + 8'h1, src} : {src ^ 8'h5a, src};
      m = ctl[1] ? 32'hff : 32'hffff;
      ew = (nwr == 2) ? {24'h0, ed[15:8]} : {16'h0, ed[15:0]};
      width_sel <= ws;
      stall_len <= st;
      ahb(1'b1, `DTCS_OFS_WAIT, w);
      ahb(1'b1, `DTCS_OFS_SRC, src);
      ahb(1'b1, `DTCS_OFS_DST, dst);
      ahb(1'b1, `DTCS_OFS_CTRL, ctl);
      rd_cnt = 0;
      wr_cnt = 0;
      dm_cnt = 0;
      ahb(1'b1, `DTCS_OFS_CTRL, ctl | 3'h1);
      if (st != 0) ahb(1'b1, `DTCS_OFS_SRC, 32'hff);
      do ahb(1'b0, `DTCS_OFS_STAT, 0); while (rv[1] !== 1'b1);
      check_range(rv[15:8], erd + ewr + lx, erd + ewr + hx,
         "total");
      check_range(rd_cnt, erd + lx, erd + hx,
         "read clocks");
      check_range(wr_cnt, ewr, ewr, "write clocks");
      check_range(dm_cnt, 1, 1, "dummy");
      ahb(1'b0, `DTCS_OFS_DATA, 0);
      check_range(rv & m, ed & m, ed & m, "data");
      check_range(wd_last, ew, ew, "write data");
      check_range(wa_last, dst + nwr - 1, dst + nwr - 1,
         "write address");
      ahb(1'b1, `DTCS_OFS_STAT, 32'h2);
      ahb(1'b0, `DTCS_OFS_STAT, 0);
      check_range(rv[1:0], 0, 0, "done clear");
      ahb(1'b0, `DTCS_OFS_SRC, 0);
      check_range(rv, src, src, "source kept");
      $display("unit done src %h dst %h waits %h", src, dst, w);
   endtask
   initial begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hwdata = 32'h0;
      width_sel = 1'b0;
      stall_len = 4'h0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      ahb(1'b0, `DTCS_OFS_STAT, 0);
      check_range(rv, 0, 0, "status reset");
      ahb(1'b1, 8'h20, 32'h5);
      ahb(1'b0, 8'h20, 0);
      check_range(rv, 0, 0, "unmapped");
      $display("register test done");
      run_case(3'h2, 1'b0, 8'h10, 8'h20, 6'h00, 4'h0, 1, 1);
      run_case(3'h0, 1'b0, 8'h11, 8'h20, 6'h00, 4'h0, 2, 1);
      run_case(3'h0, 1'b0, 8'h10, 8'h21, 6'h00, 4'h0, 1, 2);
      run_case(3'h4, 1'b1, 8'h10, 8'h20, 6'h00, 4'h0, 2, 2);
      run_case(3'h6, 1'b1, 8'h13, 8'h21, 6'h00, 4'h0, 1, 1);
      run_case(3'h0, 1'b1, 8'h10, 8'h20, 6'h00, 4'h0, 1, 1);
      run_case(3'h0, 1'b0, 8'h10, 8'h20, 6'h06, 4'h0, 1, 1);
      run_case(3'h0, 1'b0, 8'h11, 8'h22, 6'h0b, 4'h0, 2, 1);
      run_case(3'h4, 1'b0, 8'h10, 8'h20, 6'h13, 4'h6, 1, 1);
      end_of_test;
   end
endmodule // tb_dtcs_sequencer
`default_nettype wire
